// ==== nsx_datapath.sv ====
// datapath for nibble swap, xor literal/file and direction-register load
`timescale 1ns/10ps
module nsx_datapath (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                instrValid,
  input  wire nsx_pkg::nsx_op_type opCode,
  input  wire logic [6:0]          fileAddr,
  input  wire logic                destBit,
  input  wire logic [7:0]          literal,
  input  wire logic [7:0]          fileReadData,
  output logic [7:0]               accumulator,
  output logic                     zeroFlag,
  output logic                     fileWriteEn,
  output logic [6:0]               fileWriteAddr,
  output logic [7:0]               fileWriteData,
  output logic [7:0]               port_a_direction,
  output logic [7:0]               port_b_direction,
  output logic [7:0]               port_c_direction,
  output logic                     badOperand
);
  logic [7:0] result;
  logic [7:0] swapResult;
  logic [7:0] xorOperand;
  logic [7:0] next_accumulator;
  logic       next_zeroFlag;
  logic       next_fileWriteEn;
  logic       next_badOperand;
  logic       isSwap;
  logic       isXorLit;
  logic       isXorFile;
  logic       isDir;
  logic       isXor;
  logic       isFileForm;
  logic       writesAcc;
  logic       operandHighClear;
  logic       selPortA;
  logic       selPortB;
  logic       selPortC;
  logic       operandOk;

  // decode of the one-cycle instruction strobe
  assign isSwap    = instrValid && opCode == nsx_pkg::NSX_OP_NIBBLE_SWAP;
  assign isXorLit  = instrValid && opCode == nsx_pkg::NSX_OP_XOR_LITERAL;
  assign isXorFile = instrValid && opCode == nsx_pkg::NSX_OP_XOR_FILE;
  assign isDir     = instrValid && opCode == nsx_pkg::NSX_OP_DIRECTION_LOAD;

  // grouped decodes shared by the flag and write-back logic
  assign isXor      = isXorLit || isXorFile;
  assign isFileForm = isSwap || isXorFile;

  // nibble exchange of the addressed file register
  assign swapResult = {fileReadData[3:0], fileReadData[7:4]};

  // second xor operand: the immediate for the literal form, else the file
  assign xorOperand = isXorLit ? literal : fileReadData;

  // result mux; all single-cycle, no pipelining
  always_comb
  begin
    result = fileReadData;
    if (isSwap)
      result = swapResult;
    else if (isXor)
      result = accumulator ^ xorOperand;
  end

  // literal always targets the accumulator; file forms follow the d bit
  assign writesAcc = isXorLit ||
                     (isFileForm &&
                      destBit == nsx_pkg::DEST_ACC);

  // next accumulator; holds unless an instruction routes its result here
  always_comb
  begin
    next_accumulator = accumulator;
    if (writesAcc)
      next_accumulator = result;
  end

  // next zero flag; swap and direction load must leave it untouched
  always_comb
  begin
    next_zeroFlag = zeroFlag;
    if (isXor)
      next_zeroFlag = (result == nsx_pkg::ZERO_RESULT);
  end

  // write-back only for file forms whose d bit points at the file
  assign next_fileWriteEn = isFileForm &&
                            destBit == nsx_pkg::DEST_FILE;

  // accumulator register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      accumulator <= nsx_pkg::ACC_RESET;
    else
      accumulator <= next_accumulator;
  end

  // zero flag register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      zeroFlag <= nsx_pkg::ZERO_RESET;
    else
      zeroFlag <= next_zeroFlag;
  end

  // write strobe stands one cycle, so the bank sees one write per op
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      fileWriteEn <= nsx_pkg::WEN_RESET;
    else
      fileWriteEn <= next_fileWriteEn;
  end

  // write address holds until the next file form, easing bank timing
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      fileWriteAddr <= nsx_pkg::WADDR_RESET;
    else if (isFileForm)
      fileWriteAddr <= fileAddr;
  end

  // write data from a flip-flop, never straight from the mux
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      fileWriteData <= nsx_pkg::WDATA_RESET;
    else if (isFileForm)
      fileWriteData <= result;
  end

  // direction operand decode; the full seven bits must match, so
  // aliases such as 13 or 15 are refused rather than wrapped
  assign operandHighClear = fileAddr[6:3] == nsx_pkg::DIR_SEL_HIGH;
  assign selPortA = isDir && operandHighClear &&
                    fileAddr[2:0] == nsx_pkg::DIR_SEL_A;
  assign selPortB = isDir && operandHighClear &&
                    fileAddr[2:0] == nsx_pkg::DIR_SEL_B;
  assign selPortC = isDir && operandHighClear &&
                    fileAddr[2:0] == nsx_pkg::DIR_SEL_C;
  assign operandOk = selPortA || selPortB || selPortC;

  // port A direction register
  nsx_dir_reg dirRegA (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (selPortA),
    .loadData (accumulator),
    .dirValue (port_a_direction)
  );

  // port B direction register
  nsx_dir_reg dirRegB (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (selPortB),
    .loadData (accumulator),
    .dirValue (port_b_direction)
  );

  // port C direction register
  nsx_dir_reg dirRegC (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (selPortC),
    .loadData (accumulator),
    .dirValue (port_c_direction)
  );

  // refused operand: no register moves, a one-cycle pulse reports it
  assign next_badOperand = isDir && !operandOk;

  // refusal pulse register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      badOperand <= nsx_pkg::BAD_RESET;
    else
      badOperand <= next_badOperand;
  end
endmodule

// one port direction register, loaded from the accumulator when selected
module nsx_dir_reg (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       load,
  input  wire logic [7:0] loadData,
  output logic [7:0]      dirValue
);
  // all-input after reset, so no pin drives before software decides
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      dirValue <= nsx_pkg::DIR_RESET;
    else if (load)
      dirValue <= loadData;
  end
endmodule

// ==== nsx_fm.sv ====
// file register bank model on the far side of the datapath
`timescale 1ns/10ps
module nsx_fm (input wire logic core_clk, fileWriteEn,
  input wire logic [6:0] fileAddr, fileWriteAddr,
  input wire logic [7:0] fileWriteData, output logic [7:0] fileReadData);
  logic [7:0] m [128];
  initial foreach (m[i]) m[i] = 8'(i * 37); // varied contents, few zeros
  assign fileReadData = m[fileAddr]; // read settles in the same cycle
  always @(posedge core_clk)
    if (fileWriteEn) m[fileWriteAddr] <= fileWriteData;
endmodule

// ==== nsx_pkg.sv ====
// package: opcodes, widths, operand codes and reset values for the nibble/xor datapath
package nsx_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam logic [2:0] DIR_SEL_A = 3'h5;
  localparam logic [2:0] DIR_SEL_B = 3'h6;
  localparam logic [2:0] DIR_SEL_C = 3'h7;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic       ZERO_RESET = 1'h0;
  localparam logic       DEST_ACC = 1'h0;
  localparam logic       DEST_FILE = 1'h1;
  localparam logic [7:0] ZERO_RESULT = 8'h00;
  localparam logic [6:0] WADDR_RESET = 7'h00;
  localparam logic [7:0] WDATA_RESET = 8'h00;
  localparam logic       WEN_RESET = 1'h0;
  localparam logic       BAD_RESET = 1'h0;
  localparam logic [3:0] DIR_SEL_HIGH = 4'h0;
  typedef enum logic [2:0] {
    NSX_OP_NONE,
    NSX_OP_NIBBLE_SWAP,
    NSX_OP_XOR_LITERAL,
    NSX_OP_XOR_FILE,
    NSX_OP_DIRECTION_LOAD
  } nsx_op_type;
endpackage

// ==== nsx_sva.sv ====
// assertion checker bound to the datapath ports
`timescale 1ns/10ps
module nsx_sva (input wire logic core_clk, rst, instrValid, destBit,
  input wire logic zeroFlag, fileWriteEn, badOperand,
  input wire nsx_pkg::nsx_op_type opCode, input wire logic [6:0] fileAddr,
  input wire logic [7:0] literal, fileReadData, accumulator, fileWriteData,
  input wire logic [7:0] port_a_direction, port_b_direction,
  input wire logic [7:0] port_c_direction, input wire logic [6:0] fileWriteAddr);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // taken op code (0 when idle), swapped and xored file operand
  wire logic [2:0] o = instrValid ? opCode : 3'h0;
  wire logic [7:0] s = {fileReadData[3:0], fileReadData[7:4]};
  wire logic [7:0] x = accumulator ^ fileReadData;
  a_swap_res: assert property (o == 1 && !destBit |=>
    accumulator == $past(s)) else $error("swap result wrong");
  a_write_back: assert property (o == 3 && destBit |=>
    fileWriteEn && fileWriteAddr == $past(fileAddr))
    else $error("write back pulse wrong");
  a_swap_keep: assert property (o == 1 |=>
    $stable(zeroFlag)) else $error("swap changed zero flag");
  a_dir_load_c: assert property (o == 4 && fileAddr == 7'h07 |=>
    port_c_direction == $past(accumulator)) else $error("direction load c");
  a_dir_load_b: assert property (o == 4 && fileAddr == 7'h06 |=>
    port_b_direction == $past(accumulator)) else $error("direction load b");
  a_xor_lit: assert property (o == 2 |=>
    accumulator == ($past(accumulator) ^ $past(literal))) else $error("xor");
  a_xor_file: assert property (o == 3 && destBit |=>
    fileWriteData == $past(x)) else $error("xor file result wrong");
  a_dir_load: assert property (o == 4 && fileAddr == 7'h05 |=>
    port_a_direction == $past(accumulator)) else $error("direction load");
  a_dir_refuse: assert property (o == 4 &&
    (fileAddr < 7'h05 || fileAddr > 7'h07) |=>
    badOperand && $stable(port_a_direction)) else $error("not refused");
  a_zero_flag: assert property (o == 2 |=>
    zeroFlag == (accumulator == 8'h00)) else $error("zero flag wrong");
endmodule
bind nsx_datapath nsx_sva chk (.*);

// ==== test_nibble_swap_xor_dir_load.sv ====
// self-checking bench for the nibble/xor datapath
`timescale 1ns/10ps
module test_nibble_swap_xor_dir_load;
  logic core_clk = 0, rst = 1, instrValid = 0, destBit = 0, zeroFlag;
  logic fileWriteEn, badOperand;
  nsx_pkg::nsx_op_type opCode = nsx_pkg::NSX_OP_NONE;
  logic [6:0] fileAddr = 0, fileWriteAddr;
  logic [7:0] literal = 0, fileReadData, accumulator, fileWriteData, w;
  logic [7:0] port_a_direction, port_b_direction, port_c_direction;
  logic [7:0] e [3] = '{3{8'hFF}};
  int errors = 0, samples_checked = 0, n = 0;
  initial forever #2 core_clk = ~core_clk;
  nsx_datapath dut (.*);
  nsx_fm fm (.*);
  task automatic chk(logic [7:0] g, x);
    samples_checked++;
    if (g !== x) begin errors++; $display("BAD %0t %h %h", $time, g, x); end
  endtask
  // codes 1 swap, 2 xor literal, 3 xor file, 4 direction load
  task automatic go(logic [2:0] o, logic [6:0] a, logic b, logic [7:0] l);
    @(posedge core_clk); instrValid <= 1; fileAddr <= a; destBit <= b;
    opCode <= nsx_pkg::nsx_op_type'(o); literal <= l;
    @(posedge core_clk); instrValid <= 0; #1;
  endtask
  task automatic t_alu;
    go(2, 0, 0, 8'hA5); chk(accumulator, 8'hA5);
    chk(zeroFlag, 0);
    go(2, 0, 0, 8'hA5); chk(zeroFlag, 1);
    w = fm.m[9]; go(3, 9, 1, 0); chk(fileWriteData, w);
    chk(fileWriteEn, 1); chk(fileWriteAddr, 9);
    chk(accumulator, 0);
    go(3, 9, 0, 0); chk(accumulator, w);
    chk(zeroFlag, 0); chk(fileWriteEn, 0);
    go(3, 9, 0, 0); chk(accumulator, 0); chk(zeroFlag, 1);
    w = {fm.m[3][3:0], fm.m[3][7:4]};
    go(1, 3, 0, 0); chk(accumulator, w);
    chk(zeroFlag, 1);
    go(1, 3, 1, 0); chk(fileWriteData, w);
    chk(fileWriteEn, 1); chk(accumulator, w);
  endtask
  task automatic t_dir;
    for (int i = 0; i < 3; i++)
    begin
      go(2, 0, 0, 8'h11); w ^= 8'h11; e[i] = w; go(4, 7'(i + 5), 0, 0);
      chk(port_a_direction, e[0]); chk(port_b_direction, e[1]);
      chk(port_c_direction, e[2]);
      chk(badOperand, 0);
    end
    go(4, 4, 0, 0); chk(badOperand, 1);
    go(4, 8, 0, 0); chk(badOperand, 1);
    chk(port_a_direction, e[0]); chk(port_b_direction, e[1]);
    chk(port_c_direction, e[2]);
  endtask
  task automatic tally_and_finish;
    $display("errors=%0d checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, far above the few dozen cycles the scenarios need
  always @(posedge core_clk)
    if (++n > 300) begin errors++; tally_and_finish; end
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst <= 0; t_alu; t_dir; tally_and_finish;
  end
endmodule
